// ---- dual_gain_amp_consts.svh ----
`ifndef DUAL_GAIN_AMP_CONSTS_SVH
`define DUAL_GAIN_AMP_CONSTS_SVH

// Register indices, selected by the four lowest bits of a serial word
`define REG_IDX_READBACK  4'h5
`define REG_IDX_CHAIN     4'h6
`define REG_IDX_SOURCE    4'h7
`define REG_IDX_MIXER     4'hD
`define REG_IDX_GAIN      4'hE
`define REG_IDX_POWER     4'hF

// Field positions
`define SEL_MSB           3
`define SEL_LSB           0
`define RB_ADDR_MSB       31
`define RB_ADDR_LSB       28
`define CHAIN_BIT         20
`define SOURCE_BIT        22
`define GAIN_A_MSB        17
`define GAIN_A_LSB        12
`define GAIN_B_MSB        11
`define GAIN_B_LSB        6
`define AMP_EN_A_BIT      5
`define AMP_EN_B_BIT      4
`define MIX_EN_A_BIT      5
`define MIX_EN_B_BIT      4
`define LOW_POWER_BIT     16
`define STANDBY_BIT       14

// Reset values and special words
`define REG_RESET         32'h00000000
`define NOP_WORD          32'h00000000
`define GAIN_RESET        6'h00

// Serial framing and gain range
`define WORD_BITS         6'h20
`define GAIN_MAX_HALF_DB  8'h2C
`define GAIN_MIN_HALF_DB  8'hED

`endif

// ---- dual_gain_amp_pkg.sv ----
package dual_gain_amp_pkg;

    typedef logic [31:0]       reg_word_t;
    typedef logic [3:0]        reg_index_t;
    typedef logic [5:0]        gain_code_t;
    typedef logic signed [7:0] half_db_t;

    // Where each channel's gain code comes from
    typedef enum logic
    {
        SRC_SERIAL = 1'b0,
        SRC_PINS   = 1'b1
    } gain_source_t;

endpackage : dual_gain_amp_pkg

// ---- serial_bridge_if.sv ----
`timescale 1ns/100ps

// Words passed between the register core and the serial link logic
interface serial_bridge_if;
    dual_gain_amp_pkg::reg_word_t frameWord;
    dual_gain_amp_pkg::reg_word_t readWord;
    logic                         chainEnable;

    modport core
    (
        input  frameWord,
        output readWord,
        output chainEnable
    );

    modport link
    (
        output frameWord,
        input  readWord,
        input  chainEnable
    );
endinterface : serial_bridge_if

// ---- sync_bits.sv ----
`timescale 1ns/100ps

// Two flip-flop synchroniser for a group of independent levels
module sync_bits #(parameter int WIDTH = 1)
(
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_stage2;

    // First stage feeds only the second stage
    always_comb
    begin
        nxt_stage1 = asyncIn;
        nxt_stage2 = stage1_ff;
    end

    always_ff @(posedge clk)
    begin
        stage1_ff <= nxt_stage1;
        stage2_ff <= nxt_stage2;
    end

    assign syncOut = stage2_ff;
endmodule : sync_bits

// ---- serial_link.sv ----
`timescale 1ns/100ps
`include "dual_gain_amp_consts.svh"

// Link-side shifter: runs on the serial clock, which stands still between frames
module serial_link
(
    input  wire logic       serialClk,
    input  wire logic       loadStrobe,
    input  wire logic       serialDataIn,
    output logic            serialReadOutput,
    serial_bridge_if.link   bus
);
    dual_gain_amp_pkg::reg_word_t shift_ff;
    dual_gain_amp_pkg::reg_word_t readShift_ff;
    logic [5:0]                   bitCount_ff;
    logic                         sdo_ff;
    dual_gain_amp_pkg::reg_word_t nxt_shift;
    dual_gain_amp_pkg::reg_word_t nxt_readShift;
    logic [5:0]                   nxt_bitCount;
    logic                         nxt_sdo;
    logic                         chainSync;

    // Chain enable is a static level from the core domain
    sync_bits #(.WIDTH(1)) chainSyncer
    (
        .clk     (serialClk),
        .asyncIn (bus.chainEnable),
        .syncOut (chainSync)
    );

    // Shift in MSB first while the strobe is low; readback first, then pass-through
    always_comb
    begin
        nxt_shift     = shift_ff;
        nxt_readShift = readShift_ff;
        nxt_bitCount  = bitCount_ff;
        nxt_sdo       = sdo_ff;
        if (loadStrobe)
        begin
            nxt_bitCount = 6'h00;
        end
        else
        begin
            nxt_shift = {shift_ff[30:0], serialDataIn};
            if (bitCount_ff == 6'h00)
            begin
                nxt_sdo       = bus.readWord[31];
                nxt_readShift = {bus.readWord[30:0], 1'b0};
            end
            else if (bitCount_ff < `WORD_BITS)
            begin
                nxt_sdo       = readShift_ff[31];
                nxt_readShift = {readShift_ff[30:0], 1'b0};
            end
            else
            begin
                nxt_sdo = chainSync & shift_ff[31];
            end
            if (bitCount_ff < `WORD_BITS)
            begin
                nxt_bitCount = bitCount_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge serialClk)
    begin
        shift_ff     <= nxt_shift;
        readShift_ff <= nxt_readShift;
        sdo_ff       <= nxt_sdo;
    end

    // The clock stands still between frames, so the strobe itself clears the count
    always_ff @(posedge serialClk or posedge loadStrobe)
    begin
        if (loadStrobe)
        begin
            bitCount_ff <= 6'h00;
        end
        else
        begin
            bitCount_ff <= nxt_bitCount;
        end
    end

    // The last 32 bits stay still while the strobe is high
    assign bus.frameWord    = shift_ff;
    assign serialReadOutput = sdo_ff;
endmodule : serial_link

// ---- dual_gain_amp_serial_control.sv ----
`timescale 1ns/100ps
`include "dual_gain_amp_consts.svh"

// Contract
// - Channel A gain from bits 17:12
// - Gain spans +22 dB to -9.5 dB
// - Channel A gain latches when hold rises
// - Channel B gain from bits 11:6
// - Bit 5 enables channel A amplifier
// - Bit 4 enables channel B amplifier
// - Select 1111 stores power configuration register
// - Bit 16 puts both amplifiers low power
// - Bit 14 picks mixer standby or off
// - Register 5 bits 31:28 pick readback
// - Write shifts out previously selected register
// - Readback appears during the following write
// - All-zero word changes nothing
// - Load strobe frames each transfer
// - Register 6 bit 20 enables chaining
// - Registers update on strobe rising edge
// - Chain written together, read in order
// - Source bit selects parallel gain pins
// - Select 1110 stores gain register
module dual_gain_amp_serial_control #(parameter bit GAIN_DESCENDING = 1'b1)
(
    input  wire logic                               clk,
    input  wire logic                               reset,
    input  wire logic                               serialClk,
    input  wire logic                               loadStrobe,
    input  wire logic                               serialDataIn,
    input  wire logic                               channelAGainHold,
    input  wire logic [5:0]                         parallelGainA,
    input  wire logic [5:0]                         parallelGainB,
    output logic                                    serialReadOutput,
    output dual_gain_amp_pkg::gain_code_t           gainStepA,
    output dual_gain_amp_pkg::gain_code_t           gainStepB,
    output dual_gain_amp_pkg::half_db_t             gainHalfDbA,
    output dual_gain_amp_pkg::half_db_t             gainHalfDbB,
    output logic                                    ampEnableA,
    output logic                                    ampEnableB,
    output logic                                    ampLowPower,
    output logic                                    mixerEnableA,
    output logic                                    mixerEnableB,
    output logic                                    mixerStandby
);
    serial_bridge_if bridge ();

    dual_gain_amp_pkg::reg_word_t    regFile_ff [16];
    dual_gain_amp_pkg::reg_word_t    readWord_ff;
    dual_gain_amp_pkg::reg_word_t    nxt_readWord;
    dual_gain_amp_pkg::reg_word_t    capturedWord;
    dual_gain_amp_pkg::reg_index_t   writeIdx;
    dual_gain_amp_pkg::reg_index_t   readIdx;
    dual_gain_amp_pkg::gain_code_t   gainA_ff;
    dual_gain_amp_pkg::gain_code_t   gainB_ff;
    dual_gain_amp_pkg::gain_code_t   nxt_gainA;
    dual_gain_amp_pkg::gain_code_t   nxt_gainB;
    dual_gain_amp_pkg::gain_code_t   stepA_ff;
    dual_gain_amp_pkg::gain_code_t   stepB_ff;
    dual_gain_amp_pkg::gain_code_t   nxt_stepA;
    dual_gain_amp_pkg::gain_code_t   nxt_stepB;
    dual_gain_amp_pkg::half_db_t     halfDbA_ff;
    dual_gain_amp_pkg::half_db_t     halfDbB_ff;
    dual_gain_amp_pkg::half_db_t     nxt_halfDbA;
    dual_gain_amp_pkg::half_db_t     nxt_halfDbB;
    dual_gain_amp_pkg::gain_source_t gainSource;
    logic                            strobeLast_ff;
    logic                            nxt_strobeLast;
    logic                            strobeRise;
    logic                            writeEn;
    logic                            chainEnable_ff;
    logic                            nxt_chainEnable;
    logic [6:0]                      powerOut_ff;
    logic [6:0]                      nxt_powerOut;
    logic [13:0]                     pinSync;
    logic                            strobeSync;
    logic                            holdSync;
    logic [5:0]                      pinGainA;
    logic [5:0]                      pinGainB;
    logic [11:0]                     pinPrev_ff;
    logic [11:0]                     nxt_pinPrev;
    logic                            pinSteady;

    // Code to attenuator step, direction fixed by parameter
    function automatic dual_gain_amp_pkg::gain_code_t codeToStep
    (
        input dual_gain_amp_pkg::gain_code_t code
    );
        codeToStep = GAIN_DESCENDING ? code : ~code;
    endfunction : codeToStep

    // Step to gain in half-dB units: step 0 is the top of the range
    function automatic dual_gain_amp_pkg::half_db_t stepToHalfDb
    (
        input dual_gain_amp_pkg::gain_code_t step
    );
        stepToHalfDb = `GAIN_MAX_HALF_DB - {2'b00, step};
    endfunction : stepToHalfDb

    // Link-side shifter on the serial clock
    serial_link link
    (
        .serialClk        (serialClk),
        .loadStrobe       (loadStrobe),
        .serialDataIn     (serialDataIn),
        .serialReadOutput (serialReadOutput),
        .bus              (bridge.link)
    );

    // Pins enter the core domain through two flip-flops
    sync_bits #(.WIDTH(14)) pinSyncer
    (
        .clk     (clk),
        .asyncIn ({loadStrobe, channelAGainHold, parallelGainA, parallelGainB}),
        .syncOut (pinSync)
    );

    assign strobeSync = pinSync[13];
    assign holdSync   = pinSync[12];
    assign pinGainA   = pinSync[11:6];
    assign pinGainB   = pinSync[5:0];

    // Strobe edge detector; the frame word is frozen once the strobe is high
    always_comb
    begin
        nxt_strobeLast = strobeSync;
        strobeRise     = strobeSync & ~strobeLast_ff;
        capturedWord   = bridge.frameWord;
        writeIdx       = capturedWord[`SEL_MSB:`SEL_LSB];
        writeEn        = strobeRise && (capturedWord != `NOP_WORD);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            strobeLast_ff <= 1'b1;
        end
        else
        begin
            strobeLast_ff <= nxt_strobeLast;
        end
    end

    // Register file: one word per select code, includes 1110 and 1111
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
            begin
                regFile_ff[i] <= `REG_RESET;
            end
        end
        else if (writeEn)
        begin
            regFile_ff[writeIdx] <= capturedWord;
        end
    end

    // Readback word follows the stored address; the link samples it at frame start
    always_comb
    begin
        readIdx         = regFile_ff[`REG_IDX_READBACK][`RB_ADDR_MSB:`RB_ADDR_LSB];
        nxt_readWord    = regFile_ff[readIdx];
        nxt_chainEnable = regFile_ff[`REG_IDX_CHAIN][`CHAIN_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            readWord_ff    <= `REG_RESET;
            chainEnable_ff <= 1'b0;
        end
        else
        begin
            readWord_ff    <= nxt_readWord;
            chainEnable_ff <= nxt_chainEnable;
        end
    end

    assign bridge.readWord    = readWord_ff;
    assign bridge.chainEnable = chainEnable_ff;

    // Gain source and per-channel gain codes
    always_comb
    begin
        gainSource = dual_gain_amp_pkg::gain_source_t'(
            regFile_ff[`REG_IDX_SOURCE][`SOURCE_BIT]);
        nxt_gainB  = gainB_ff;
        nxt_gainA  = gainA_ff;
        // Pin codes cross bit by bit, so take them only once two samples agree
        nxt_pinPrev = pinSync[11:0];
        pinSteady   = (pinSync[11:0] == pinPrev_ff);
        case (gainSource)
            dual_gain_amp_pkg::SRC_PINS:
            begin
                if (pinSteady)
                begin
                    nxt_gainB = pinGainB;
                    if (!holdSync)
                    begin
                        nxt_gainA = pinGainA;
                    end
                end
            end
            dual_gain_amp_pkg::SRC_SERIAL:
            begin
                nxt_gainB = regFile_ff[`REG_IDX_GAIN][`GAIN_B_MSB:`GAIN_B_LSB];
                if (!holdSync)
                begin
                    nxt_gainA = regFile_ff[`REG_IDX_GAIN][`GAIN_A_MSB:`GAIN_A_LSB];
                end
            end
            default:
            begin
                nxt_gainB = gainB_ff;
                nxt_gainA = gainA_ff;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            gainA_ff   <= `GAIN_RESET;
            gainB_ff   <= `GAIN_RESET;
            pinPrev_ff <= 12'h000;
        end
        else
        begin
            gainA_ff   <= nxt_gainA;
            gainB_ff   <= nxt_gainB;
            pinPrev_ff <= nxt_pinPrev;
        end
    end

    // Attenuator steps and gain in half-dB units, registered for the outputs
    always_comb
    begin
        nxt_stepA   = codeToStep(gainA_ff);
        nxt_stepB   = codeToStep(gainB_ff);
        nxt_halfDbA = stepToHalfDb(nxt_stepA);
        nxt_halfDbB = stepToHalfDb(nxt_stepB);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stepA_ff   <= `GAIN_RESET;
            stepB_ff   <= `GAIN_RESET;
            halfDbA_ff <= `GAIN_MAX_HALF_DB;
            halfDbB_ff <= `GAIN_MAX_HALF_DB;
        end
        else
        begin
            stepA_ff   <= nxt_stepA;
            stepB_ff   <= nxt_stepB;
            halfDbA_ff <= nxt_halfDbA;
            halfDbB_ff <= nxt_halfDbB;
        end
    end

    // Amplifier and mixer power controls
    always_comb
    begin
        nxt_powerOut[6] = regFile_ff[`REG_IDX_GAIN][`AMP_EN_A_BIT];
        nxt_powerOut[5] = regFile_ff[`REG_IDX_GAIN][`AMP_EN_B_BIT];
        nxt_powerOut[4] = regFile_ff[`REG_IDX_POWER][`LOW_POWER_BIT];
        nxt_powerOut[3] = regFile_ff[`REG_IDX_MIXER][`MIX_EN_A_BIT];
        nxt_powerOut[2] = regFile_ff[`REG_IDX_MIXER][`MIX_EN_B_BIT];
        nxt_powerOut[1] = regFile_ff[`REG_IDX_POWER][`STANDBY_BIT];
        nxt_powerOut[0] = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            powerOut_ff <= 7'h00;
        end
        else
        begin
            powerOut_ff <= nxt_powerOut;
        end
    end

    // Outputs straight from flip-flops
    assign gainStepA    = stepA_ff;
    assign gainStepB    = stepB_ff;
    assign gainHalfDbA  = halfDbA_ff;
    assign gainHalfDbB  = halfDbB_ff;
    assign ampEnableA   = powerOut_ff[6];
    assign ampEnableB   = powerOut_ff[5];
    assign ampLowPower  = powerOut_ff[4];
    assign mixerEnableA = powerOut_ff[3];
    assign mixerEnableB = powerOut_ff[2];
    assign mixerStandby = powerOut_ff[1];
endmodule : dual_gain_amp_serial_control

// ---- dual_gain_amp_serial_control_properties.sv ----
`timescale 1ns/100ps

// Watches the core-side outputs of the serial control block
module dual_gain_amp_serial_control_properties
(
    input wire logic                          clk,
    input wire logic                          reset,
    input wire logic                          loadStrobe,
    input wire logic                          channelAGainHold,
    input wire dual_gain_amp_pkg::gain_code_t gainStepA,
    input wire dual_gain_amp_pkg::gain_code_t gainStepB,
    input wire dual_gain_amp_pkg::half_db_t   gainHalfDbA,
    input wire dual_gain_amp_pkg::half_db_t   gainHalfDbB,
    input wire logic                          ampEnableA,
    input wire logic                          ampEnableB,
    input wire logic                          ampLowPower,
    input wire logic                          mixerEnableA,
    input wire logic                          mixerEnableB,
    input wire logic                          mixerStandby
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    // Leaving reset: full gain, every block off
    property p_reset_state;
        $fell(reset) |-> gainHalfDbA == 8'h2C && gainHalfDbB == 8'h2C && !ampEnableA
            && !ampEnableB && !ampLowPower && !mixerEnableA && !mixerEnableB && !mixerStandby;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("not at reset state");

    property p_reset_step;
        $fell(reset) |-> gainStepA == 6'h00 && gainStepB == 6'h00;
    endproperty
    a_reset_step: assert property (p_reset_step) else $error("step not zero");

    // Half-dB gain tracks the attenuator step from +22 dB down
    property p_halfdb_a;
        gainHalfDbA == 8'h2C - {2'h0, gainStepA};
    endproperty
    a_halfdb_a: assert property (p_halfdb_a) else $error("channel A gain mismatch");

    property p_halfdb_b;
        gainHalfDbB == 8'h2C - {2'h0, gainStepB};
    endproperty
    a_halfdb_b: assert property (p_halfdb_b) else $error("channel B gain mismatch");

    // Register-driven levels move only after a strobe rise
    property p_amp_commit;
        $changed(ampEnableA) || $changed(ampEnableB) |-> $past(loadStrobe, 3);
    endproperty
    a_amp_commit: assert property (p_amp_commit) else $error("enable moved early");

    property p_power_commit;
        $changed(ampLowPower) || $changed(mixerStandby) |-> $past(loadStrobe, 3);
    endproperty
    a_power_commit: assert property (p_power_commit) else $error("power moved early");

    property p_mixer_commit;
        $changed(mixerEnableA) || $changed(mixerEnableB) |-> $past(loadStrobe, 3);
    endproperty
    a_mixer_commit: assert property (p_mixer_commit) else $error("mixer moved early");

    // A held channel A gain stays frozen
    property p_hold_freeze;
        channelAGainHold [*6] |=> $stable(gainStepA);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("held gain moved");
endmodule : dual_gain_amp_serial_control_properties

bind dual_gain_amp_serial_control dual_gain_amp_serial_control_properties u_props
(
    .clk(clk), .reset(reset), .loadStrobe(loadStrobe), .channelAGainHold(channelAGainHold),
    .gainStepA(gainStepA), .gainStepB(gainStepB), .gainHalfDbA(gainHalfDbA),
    .gainHalfDbB(gainHalfDbB), .ampEnableA(ampEnableA), .ampEnableB(ampEnableB),
    .ampLowPower(ampLowPower), .mixerEnableA(mixerEnableA), .mixerEnableB(mixerEnableB),
    .mixerStandby(mixerStandby)
);

// ---- serial_ctl_model.sv ----
`timescale 1ns/100ps

// Serial controller on the far side of the four-wire port
module serial_ctl_model
(
    output logic      serialClk,
    output logic      loadStrobe,
    output logic      serialDataIn,
    input  wire logic serialReadOutput
);
    // Idle: strobe high, clock parked low
    initial
    begin
        serialClk = 1'b0;
        loadStrobe = 1'b1;
        serialDataIn = 1'b0;
    end

    // One frame of n bits, MSB first; output captured after each rise
    task automatic xfer(input logic [63:0] bits, input int n, output logic [63:0] got);
        got = '0;
        loadStrobe = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            serialDataIn = bits[63 - k];
            #6 serialClk = 1'b1;
            #6 got[n - 1 - k] = serialReadOutput;
            serialClk = 1'b0;
        end
        #6 loadStrobe = 1'b1;
        serialDataIn = ~serialDataIn;       // Released line shows no stale value
        #250;
    endtask : xfer
endmodule : serial_ctl_model

// ---- dual_gain_amp_serial_control_bench.sv ----
`timescale 1ns/100ps
`include "dual_gain_amp_consts.svh"

module dual_gain_amp_serial_control_bench;
    typedef struct {logic [31:0] w; logic [5:0] a; logic [5:0] b; logic ea; logic eb;} row_t;

    logic                          clk;
    logic                          reset;
    logic                          serialClk;
    logic                          loadStrobe;
    logic                          serialDataIn;
    logic                          channelAGainHold;
    logic [5:0]                    parallelGainA;
    logic [5:0]                    parallelGainB;
    logic                          serialReadOutput;
    dual_gain_amp_pkg::gain_code_t gainStepA;
    dual_gain_amp_pkg::gain_code_t gainStepB;
    dual_gain_amp_pkg::half_db_t   gainHalfDbA;
    dual_gain_amp_pkg::half_db_t   gainHalfDbB;
    logic                          ampEnableA;
    logic                          ampEnableB;
    logic                          ampLowPower;
    logic                          mixerEnableA;
    logic                          mixerEnableB;
    logic                          mixerStandby;
    logic [63:0]                   got;
    int                            mismatches = 0;
    int                            nCompared = 0;
    int                            cycles = 0;
    // Words for the gain register, plus a register C write and a no-op word, with the outputs each should leave
    row_t rows [0:5] = '{'{32'h00000FEE, 6'h00, 6'h3F, 1'b1, 1'b0},
                         '{32'h0003F01E, 6'h3F, 6'h00, 1'b0, 1'b1},
                         '{32'h0003F03C, 6'h3F, 6'h00, 1'b0, 1'b1},
                         '{32'h000010BE, 6'h01, 6'h02, 1'b1, 1'b1},
                         '{32'h00000000, 6'h01, 6'h02, 1'b1, 1'b1},
                         '{32'h8002A57E, 6'h2A, 6'h15, 1'b1, 1'b1}};

    dual_gain_amp_serial_control u_dut
    (
        .clk(clk), .reset(reset), .serialClk(serialClk), .loadStrobe(loadStrobe),
        .serialDataIn(serialDataIn), .channelAGainHold(channelAGainHold),
        .parallelGainA(parallelGainA), .parallelGainB(parallelGainB),
        .serialReadOutput(serialReadOutput), .gainStepA(gainStepA), .gainStepB(gainStepB),
        .gainHalfDbA(gainHalfDbA), .gainHalfDbB(gainHalfDbB), .ampEnableA(ampEnableA),
        .ampEnableB(ampEnableB), .ampLowPower(ampLowPower), .mixerEnableA(mixerEnableA),
        .mixerEnableB(mixerEnableB), .mixerStandby(mixerStandby)
    );

    serial_ctl_model u_ctl
    (
        .serialClk(serialClk), .loadStrobe(loadStrobe), .serialDataIn(serialDataIn),
        .serialReadOutput(serialReadOutput)
    );

    // Core clock, 25 ns
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic ok, input string msg);
        nCompared++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic check_gain(input logic [5:0] a, input logic [5:0] b, input logic ea,
                              input logic eb);
        chk(gainStepA === a && gainHalfDbA === `GAIN_MAX_HALF_DB - {2'h0, a}, "gain A");
        chk(gainStepB === b && gainHalfDbB === `GAIN_MAX_HALF_DB - {2'h0, b}, "gain B");
        chk({ampEnableA, ampEnableB} === {ea, eb}, "amp enables");
    endtask : check_gain

    task automatic wr(input logic [31:0] w);
        u_ctl.xfer({w, 32'h0}, 32, got);
    endtask : wr

    task automatic pulse_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);                                            // Settled after release
        check_gain(6'h00, 6'h00, 1'b0, 1'b0);
        chk({ampLowPower, mixerEnableA, mixerEnableB, mixerStandby} === 4'h0, "reset levels");
    endtask : pulse_reset

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            mismatches++;
            test_done();
        end
    end

    initial
    begin
        reset = 1'b1;
        channelAGainHold = 1'b0;
        parallelGainA = 6'h00;
        parallelGainB = 6'h00;
        pulse_reset();
        for (int r = 15; r >= 0; r--)
            wr({28'h0, r[3:0]});
        check_gain(6'h00, 6'h00, 1'b0, 1'b0);
        foreach (rows[i])
        begin
            wr(rows[i].w);
            check_gain(rows[i].a, rows[i].b, rows[i].ea, rows[i].eb);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr({15'h0, i[1], 1'b0, i[0], 10'h0, 4'hF});
            wr({26'h0, i[1], i[0], 4'hD});
            chk({ampLowPower, mixerStandby} === i[1:0], "power config");
            chk({mixerEnableA, mixerEnableB} === i[1:0], "mixer enables");
        end
        wr(32'hE0000005);
        chk(got[31:0] === 32'h0, "readback of old address");
        wr(32'h00000000);
        chk(got[31:0] === 32'h8002A57E, "readback gain register");
        wr(32'hF0000005);
        chk(got[31:0] === 32'h8002A57E, "readback before change");
        @(posedge clk);
        channelAGainHold <= 1'b1;
        repeat (4) @(posedge clk);
        wr(32'h0000A0BE);
        check_gain(6'h2A, 6'h02, 1'b1, 1'b1);
        @(posedge clk);
        channelAGainHold <= 1'b0;
        repeat (6) @(negedge clk);
        check_gain(6'h0A, 6'h02, 1'b1, 1'b1);
        @(posedge clk);
        parallelGainA <= 6'h15;
        parallelGainB <= 6'h2A;
        wr(32'h00400007);
        check_gain(6'h15, 6'h2A, 1'b1, 1'b1);
        @(posedge clk);
        parallelGainA <= 6'h3F;
        repeat (8) @(negedge clk);
        check_gain(6'h3F, 6'h2A, 1'b1, 1'b1);
        chk(gainHalfDbA === `GAIN_MIN_HALF_DB, "gain floor");
        wr(32'h00000007);
        check_gain(6'h0A, 6'h02, 1'b1, 1'b1);
        wr(32'h00100006);
        u_ctl.xfer({32'h5A5AC3F1, 32'h0}, 64, got);
        chk(got === {32'h0001400F, 32'h5A5AC3F1}, "chain readback");
        check_gain(6'h0A, 6'h02, 1'b1, 1'b1);
        u_ctl.xfer({32'h12345678, 32'h0000F0FE}, 64, got);
        chk(got[31:0] === 32'h12345678, "chain pass-through");
        check_gain(6'h0F, 6'h03, 1'b1, 1'b1);
        wr(32'h00000006);
        u_ctl.xfer({32'hFFFFFFFF, 32'h0}, 64, got);
        chk(got[31:0] === 32'h0, "no pass-through unchained");
        check_gain(6'h0F, 6'h03, 1'b1, 1'b1);
        pulse_reset();
        wr(32'h00000000);
        chk(got[31:0] === 32'h0, "readback after reset");
        test_done();
    end
endmodule : dual_gain_amp_serial_control_bench
